// file: bench/sts_meter.sv
// Purpose: Meter model on the wired trigger lines
// Assumes: Open drain lines with pull-ups
// Notes: A trigger landing mid measurement is dropped
`timescale 1ns/1ps
`default_nettype none
module sts_meter (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [5:0] line_i,
  input wire logic semi_i,
  input wire logic slow_i,
  input wire logic [2:0] wsel_i,
  input wire logic [2:0] asel_i,
  output logic [5:0] oe_o,
  output logic [7:0] meas_o
);
  logic [1:0] hist;
  logic [7:0] cnt;
  logic pull;
  // Async answer is a late pulse, long enough to pass the input filter
  assign pull = semi_i ? cnt != 8'h00 : cnt != 8'h00 && cnt < 8'h0a;
  assign oe_o = pull ? 6'h01 << asel_i : 6'h00;
  always_ff @(posedge clk_i) begin
    hist <= {hist[0], line_i[wsel_i]};
    if (rst_i) begin
      cnt <= 8'h00;
      meas_o <= 8'h00;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end else if (hist == 2'b10) begin
      cnt <= slow_i ? 8'hff : 8'h0c;
      meas_o <= meas_o + 8'h01;
    end
  end
endmodule
`default_nettype wire

// file: bench/sts_sequencer_checker.sv
// Purpose: Port checks for the sequencer
// Assumes: One clock, sync reset
// Notes: Bound after the module
`timescale 1ns/1ps
`default_nettype none
module sts_sequencer_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [sts_pkg::STS_LINES-1:0] meter_start_key_line_o,
  input wire logic [sts_pkg::STS_LINES-1:0] meter_start_key_line_oe_o,
  input wire logic chan_valid_o,
  input wire logic open_all_o,
  input wire logic busy_o
);
  import sts_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("long ack");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("stray ack");
  drive_zero_a: assert property (meter_start_key_line_o == '0)
    else $error("line driven high");
  one_line_a: assert property ($onehot0(meter_start_key_line_oe_o))
    else $error("two lines pulled");
  dummy_open_a: assert property (open_all_o |-> !chan_valid_o)
    else $error("dummy with relay");
  close_busy_a: assert property ($rose(chan_valid_o) |-> busy_o)
    else $error("close while idle");
  reset_quiet_a: assert property ($fell(rst_i) |->
    !busy_o && !chan_valid_o && meter_start_key_line_oe_o == '0) else $error("busy after reset");
  cover property ($rose(busy_o));
  cover property ($rose(open_all_o));
  cover property ($rose(|meter_start_key_line_oe_o));
endmodule
bind sts_sequencer sts_sequencer_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .meter_start_key_line_o, .meter_start_key_line_oe_o, .chan_valid_o, .open_all_o, .busy_o);
`default_nettype wire

// file: bench/sts_sequencer_test.sv
// Purpose: Scenario bench for the sequencer
// Assumes: Meter model on the lines, short settle
// Notes: Entries checked in order through a queue
`timescale 1ns/1ps
`default_nettype none
module sts_sequencer_test;
  import sts_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic wb_ack_o, chan_valid_o, open_all_o, busy_o, semi = 1'b1, slow = 1'b0, on = 1'b0;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, q;
  logic [7:0] wb_adr_i = 8'h00, chan_o, meas, last = 8'h00, e, want;
  logic [5:0] meter_start_key_line_o, meter_start_key_line_oe_o, m_oe, hold = 6'h00;
  logic [2:0] wsel = 3'h1, asel = 3'h1;
  wire logic [5:0] meter_start_key_line_i;
  logic [7:0] exp_q[$];
  int n_errors = 0, samples_checked = 0;
  always #2 clk_i = ~clk_i;
  assign meter_start_key_line_i = ~(meter_start_key_line_oe_o | m_oe | hold);
  sts_sequencer #(.SETTLE_CYC(4)) u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .meter_start_key_line_i, .meter_start_key_line_o,
    .meter_start_key_line_oe_o, .chan_o, .chan_valid_o, .open_all_o, .busy_o);
  sts_meter u_met (.clk_i, .rst_i, .line_i(meter_start_key_line_i), .semi_i(semi), .slow_i(slow),
    .wsel_i(wsel), .asel_i(asel), .oe_o(m_oe), .meas_o(meas));
  task automatic wrap_up();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, g, x);
    end
  endtask
  task automatic bail(input int n, input int lim);
    if (n >= lim) begin
      n_errors++;
      wrap_up();
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    bail(n, 50);
  endtask
  // Abort first, since it also empties the list
  task automatic run(input logic [31:0] cfg, input logic [31:0] cnt, input int n, input int d);
    e = 8'($urandom_range(0, 99));
    wb(1'b1, STS_REG_CTRL, 32'h0000_0002);
    wb(1'b1, STS_REG_CFG, cfg);
    wb(1'b1, STS_REG_COUNT, cnt);
    for (int k = 0; k < n + d; k++) begin
      wb(1'b1, STS_REG_LIST, {24'h0, k < n ? e + 8'(k) : STS_DUMMY_CODE});
    end
    for (int k = 0; k < int'(cnt[31:16]) * (n + d); k++) begin
      exp_q.push_back(k % (n + d) < n ? e + 8'(k % (n + d)) : STS_DUMMY_CODE);
    end
    wb(1'b1, STS_REG_CTRL, 32'h0000_0001);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (20) @(posedge clk_i);
    while (busy_o !== 1'b0 && n < 20000) begin
      @(posedge clk_i);
      n++;
    end
    bail(n, 20000);
    chk(exp_q.size(), 0);
  endtask
  always @(posedge clk_i) begin
    if ((chan_valid_o || open_all_o) && (!on || chan_o !== last)) begin
      want = exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx;
      chk({24'h0, chan_o}, {24'h0, want});
      chk({31'h0, open_all_o}, {31'h0, want == STS_DUMMY_CODE});
    end
    on <= chan_valid_o || open_all_o;
    last <= chan_o;
  end
  initial begin
    void'($urandom(32'h4d3a_c0bf));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, STS_REG_CFG, 32'h0000_0000);
    chk(q, STS_CFG_RESET);
    wb(1'b0, STS_REG_COUNT, 32'h0000_0000);
    chk(q, STS_COUNT_RESET);
    wb(1'b1, 8'h18, $urandom);
    wb(1'b0, 8'h18, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    wb(1'b1, STS_REG_SETTLE, 32'h0000_0004);
    run(32'h0000_101c, 32'h0001_0001, 3, 0);
    for (int i = 0; i < 2000 && meas !== 8'h01; i++) begin
      @(posedge clk_i);
      bail(i + 1, 2000);
    end
    hold <= 6'h02;
    repeat (60) @(posedge clk_i);
    chk({24'h0, chan_o}, {24'h0, e});
    hold <= 6'h00;
    wait_idle();
    chk({24'h0, meas}, 32'h0000_0003);
    semi <= 1'b0;
    slow <= 1'b1;
    wsel <= 3'h2;
    asel <= 3'h3;
    run(32'h0000_1234, 32'h0002_0001, 2, 1);
    wait_idle();
    chk({31'h0, meas > 8'h03}, 32'h0000_0001);
    wrap_up();
  end
endmodule
`default_nettype wire

// file: src/sts_list_mem.sv
// Purpose: Scan list storage
// Assumes: Single clock, registered read
// Notes: Entry value STS_DUMMY_CODE opens all relays
`timescale 1ns/1ps
`default_nettype none
module sts_list_mem #(
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW = 4
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [DEPTH];
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule
`default_nettype wire

// file: src/sts_pkg.sv
// Purpose: Constants for the trigger sequencer
// Assumes: 250 MHz clock, 32-bit classic Wishbone register bus
// Notes: Word-aligned register map
package sts_pkg;
  localparam int unsigned STS_CLK_MHZ = 250;
  localparam int unsigned STS_SETTLE_US = 10;
  localparam int unsigned STS_SETTLE_CYC = STS_SETTLE_US * STS_CLK_MHZ;
  localparam int unsigned STS_PULSE_US = 1;
  localparam int unsigned STS_PULSE_CYC = STS_PULSE_US * STS_CLK_MHZ;
  localparam int unsigned STS_FILT_CYC = 4;
  localparam int unsigned STS_LINES = 6;
  localparam int unsigned STS_LIST_DEPTH = 16;
  localparam logic [7:0] STS_REG_CTRL = 8'h00;
  localparam logic [7:0] STS_REG_CFG = 8'h04;
  localparam logic [7:0] STS_REG_COUNT = 8'h08;
  localparam logic [7:0] STS_REG_STATUS = 8'h0c;
  localparam logic [7:0] STS_REG_LIST = 8'h10;
  localparam logic [7:0] STS_REG_SETTLE = 8'h14;
  localparam int unsigned STS_CTRL_START = 0;
  localparam int unsigned STS_CTRL_ABORT = 1;
  localparam int unsigned STS_CFG_ARM_METER_START_KEY = 0;
  localparam int unsigned STS_CFG_SCAN_METER_START_KEY = 1;
  localparam int unsigned STS_CFG_CHAN_SRC = 2;
  localparam int unsigned STS_CFG_SEMI = 3;
  localparam int unsigned STS_CFG_IN_LSB = 4;
  localparam int unsigned STS_CFG_OUT_LSB = 8;
  localparam int unsigned STS_CFG_USE_LIST = 12;
  localparam logic [31:0] STS_CFG_RESET = 32'h0000_1204;
  localparam logic [31:0] STS_COUNT_RESET = 32'h0001_0001;
  localparam logic [7:0] STS_DUMMY_CODE = 8'hff;
  typedef enum logic [2:0] {
    STS_IDLE, STS_WAIT_METER_START_KEY, STS_CLOSE, STS_SETTLE, STS_SIGNAL, STS_HOLD
  } sts_state_e;
endpackage

// file: src/sts_sequencer.sv
// Purpose: Channel scan trigger sequencer with wired trigger handoff
// Assumes: Trigger lines open drain, pulled high off chip
// Notes: Relays driven by chan_o, dummy entry raises open_all_o
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Source control skips first channel wait
// - Semi mode pulls shared line after settling
// - Later channels wait for input trigger
// - Rising edge closes next, pulls again
// - Immediate arm and scan pass straight through
// - Channel layer async or semi mode, line select
// - Dummy list entry opens every channel
// - Repeat list for scan count, then idle
// - Reset defaults immediate, source, list length
// - Wired-AND line waits for all participants
// - Async mode pulses separate output line
module sts_sequencer #(
  parameter int unsigned SETTLE_CYC = sts_pkg::STS_SETTLE_CYC,
  parameter int unsigned DEPTH = sts_pkg::STS_LIST_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [sts_pkg::STS_LINES-1:0] meter_start_key_line_i,
  output logic [sts_pkg::STS_LINES-1:0] meter_start_key_line_o,
  output logic [sts_pkg::STS_LINES-1:0] meter_start_key_line_oe_o,
  output logic [7:0] chan_o,
  output logic chan_valid_o,
  output logic open_all_o,
  output logic busy_o
);
  import sts_pkg::*;
  localparam int unsigned AW = $clog2(DEPTH);

  logic [31:0] cfg;
  logic [15:0] chan_count;
  logic [15:0] scan_count;
  logic [31:0] settle_cfg;
  logic [AW:0] list_len;
  logic start_req;
  logic abort_req;
  sts_state_e state;
  logic first_pass;
  logic [15:0] chan_idx;
  logic [15:0] scan_idx;
  logic [31:0] timer;
  logic [AW-1:0] rd_ptr;
  logic [7:0] entry;
  logic mem_we;
  logic [STS_LINES-1:0] sync1;
  logic [STS_LINES-1:0] sync2;
  logic [2:0] filt_cnt;
  logic line_f;
  logic line_f_d;
  logic rise_ev;
  logic fall_ev;
  logic async_ev;
  logic meter_start_key_ev;
  logic [2:0] in_sel;
  logic [2:0] out_sel;
  logic semi;
  logic [15:0] eff_chans;
  logic bus_req;

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign in_sel = cfg[STS_CFG_IN_LSB +: 3];
  assign out_sel = cfg[STS_CFG_OUT_LSB +: 3];
  assign semi = cfg[STS_CFG_SEMI];
  assign eff_chans = cfg[STS_CFG_USE_LIST] ? 16'(list_len) : chan_count;
  // A full list refuses appends, else the write would wrap onto entry 0
  assign mem_we = bus_req && wb_we_i && (wb_adr_i == STS_REG_LIST) && wb_sel_i[0] &&
      (list_len < (AW+1)'(DEPTH));

  function automatic logic line_bit(input logic [STS_LINES-1:0] v, input logic [2:0] sel);
    logic r;
    r = 1'b1;
    if (sel < 3'(STS_LINES)) begin
      r = v[sel];
    end
    return r;
  endfunction

  // Wishbone slave, one registered ack per request, the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg <= STS_CFG_RESET;
      chan_count <= STS_COUNT_RESET[15:0];
      scan_count <= STS_COUNT_RESET[31:16];
      settle_cfg <= 32'(SETTLE_CYC);
      list_len <= '0;
    end else if (bus_req && wb_we_i) begin
      if (wb_adr_i == STS_REG_CFG) begin
        cfg <= wb_dat_i;
      end else if (wb_adr_i == STS_REG_COUNT) begin
        chan_count <= wb_dat_i[15:0];
        scan_count <= wb_dat_i[31:16];
      end else if (wb_adr_i == STS_REG_SETTLE) begin
        settle_cfg <= wb_dat_i;
      end else if (wb_adr_i == STS_REG_LIST && wb_sel_i[0]) begin
        if (list_len < (AW+1)'(DEPTH)) begin
          list_len <= list_len + 1'b1;
        end
      end else if (wb_adr_i == STS_REG_CTRL && wb_dat_i[STS_CTRL_ABORT]) begin
        list_len <= '0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_req <= 1'b0;
      abort_req <= 1'b0;
    end else begin
      start_req <= bus_req && wb_we_i && wb_adr_i == STS_REG_CTRL && wb_dat_i[STS_CTRL_START];
      abort_req <= bus_req && wb_we_i && wb_adr_i == STS_REG_CTRL && wb_dat_i[STS_CTRL_ABORT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (bus_req && !wb_we_i) begin
      if (wb_adr_i == STS_REG_CFG) begin
        wb_dat_o <= cfg;
      end else if (wb_adr_i == STS_REG_COUNT) begin
        wb_dat_o <= {scan_count, chan_count};
      end else if (wb_adr_i == STS_REG_STATUS) begin
        wb_dat_o <= {1'b0, first_pass, scan_idx[7:0], chan_idx[7:0], 5'(list_len), 8'(state),
            busy_o};
      end else if (wb_adr_i == STS_REG_SETTLE) begin
        wb_dat_o <= settle_cfg;
      end else begin
        wb_dat_o <= '0;
      end
    end
  end

  sts_list_mem #(.DEPTH(DEPTH), .AW(AW)) u_list (
    .clk_i(clk_i),
    .we_i(mem_we),
    .waddr_i(list_len[AW-1:0]),
    .wdata_i(wb_dat_i[7:0]),
    .raddr_i(rd_ptr),
    .rdata_o(entry)
  );

  // Two-stage synchroniser, then a glitch filter on the selected line
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= '1;
      sync2 <= '1;
    end else begin
      sync1 <= meter_start_key_line_i;
      sync2 <= sync1;
    end
  end

  // Filter trades a few cycles of latency for one event per edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filt_cnt <= '0;
      line_f <= 1'b1;
      line_f_d <= 1'b1;
    end else begin
      line_f_d <= line_f;
      if (line_bit(sync2, in_sel) == line_f) begin
        filt_cnt <= '0;
      end else if (filt_cnt == 3'(STS_FILT_CYC - 1)) begin
        filt_cnt <= '0;
        line_f <= ~line_f;
      end else begin
        filt_cnt <= filt_cnt + 1'b1;
      end
    end
  end

  assign rise_ev = line_f && !line_f_d;
  assign fall_ev = !line_f && line_f_d;
  assign async_ev = fall_ev;
  assign meter_start_key_ev = semi ? rise_ev : async_ev;

  always_ff @(posedge clk_i) begin
    if (rst_i || abort_req) begin
      state <= STS_IDLE;
      first_pass <= 1'b0;
      chan_idx <= '0;
      scan_idx <= '0;
      rd_ptr <= '0;
      timer <= '0;
    end else begin
      case (state)
        STS_IDLE: begin
          if (start_req && eff_chans != 16'h0000) begin
            first_pass <= 1'b1;
            chan_idx <= '0;
            scan_idx <= '0;
            rd_ptr <= '0;
            if (cfg[STS_CFG_CHAN_SRC]) begin
              state <= STS_CLOSE;
            end else begin
              state <= STS_WAIT_METER_START_KEY;
            end
          end
        end
        STS_WAIT_METER_START_KEY: begin
          if (meter_start_key_ev) begin
            state <= STS_CLOSE;
          end
        end
        STS_CLOSE: begin
          timer <= settle_cfg;
          state <= STS_SETTLE;
        end
        STS_SETTLE: begin
          if (timer <= 32'h0000_0001) begin
            timer <= 32'(STS_PULSE_CYC);
            state <= STS_SIGNAL;
          end else begin
            timer <= timer - 1'b1;
          end
        end
        STS_SIGNAL: begin
          // Semi mode keeps pulling until the line reads low, so the meter has seen it
          if (semi ? !line_f : timer <= 32'h0000_0001) begin
            // Wrap one cycle early, the list read is registered
            if (chan_idx + 1'b1 >= eff_chans) begin
              rd_ptr <= '0;
            end
            state <= STS_HOLD;
          end else if (!semi) begin
            timer <= timer - 1'b1;
          end
        end
        STS_HOLD: begin
          first_pass <= 1'b0;
          if (chan_idx + 1'b1 < eff_chans) begin
            chan_idx <= chan_idx + 1'b1;
            rd_ptr <= rd_ptr + 1'b1;
            state <= STS_WAIT_METER_START_KEY;
          end else if (scan_idx + 1'b1 < scan_count) begin
            scan_idx <= scan_idx + 1'b1;
            chan_idx <= '0;
            rd_ptr <= '0;
            state <= cfg[STS_CFG_CHAN_SRC] ? STS_CLOSE : STS_WAIT_METER_START_KEY;
          end else begin
            state <= STS_IDLE;
          end
        end
        default: begin
          state <= STS_IDLE;
        end
      endcase
    end
  end

  // Semi mode lets go once the line reads low; the meter then owns the low phase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meter_start_key_line_oe_o <= '0;
      meter_start_key_line_o <= '0;
    end else begin
      meter_start_key_line_o <= '0;
      meter_start_key_line_oe_o <= '0;
      if (!semi && state == STS_SIGNAL && out_sel < 3'(STS_LINES)) begin
        meter_start_key_line_oe_o[out_sel] <= 1'b1;
      end
      if (semi && (state == STS_SIGNAL || state == STS_HOLD) && in_sel < 3'(STS_LINES)) begin
        meter_start_key_line_oe_o[in_sel] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_o <= '0;
      chan_valid_o <= 1'b0;
      open_all_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      busy_o <= state != STS_IDLE;
      if (state == STS_CLOSE) begin
        chan_o <= entry;
        open_all_o <= entry == STS_DUMMY_CODE;
        chan_valid_o <= entry != STS_DUMMY_CODE;
      end else if (state == STS_IDLE) begin
        chan_valid_o <= 1'b0;
        open_all_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire
